//--- include/bsc_pkg.sv
// constants, state codes, register map and carriers of the burner sequencer
// assumes a 20 MHz system clock and a 32-bit ahb-lite register bus
package bsc_pkg;

  // ==========================================================
  // clock and time base
  localparam int CLK_PERIOD_NS = 50;
  localparam int SEC_NS        = 1000000000;
  localparam int SEC_CYC       = SEC_NS / CLK_PERIOD_NS;
  localparam int MIN_S         = 60;

  // ==========================================================
  // state times, in seconds
  localparam logic [8:0] INIT_S     = 9'h00a; // stabilisation period
  localparam logic [2:0] FAULT_IND_S = 3'h5;  // least fault indication
  localparam logic [8:0] TRANS_S    = 9'h001; // settle before part one
  localparam logic [8:0] LF_GRACE_S = 9'h002; // low-fire bounce allowed
  localparam logic [8:0] IGN_S      = 9'h004; // ignition trial
  localparam logic [8:0] N2_S       = 9'h005; // main flame trial
  localparam logic [8:0] HL1_S      = 9'h004; // stepfire trial
  localparam logic [8:0] ALARM_S    = 9'(4 * MIN_S);
  localparam logic [8:0] LOCK_S     = 9'(8 * MIN_S);
  localparam logic [1:0] DEB_S      = 2'h3;   // ticks, gives 2 to 3 s

  // ==========================================================
  // register map (byte addresses) and fields
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TIMER  = 8'h08;
  localparam int CTRL_SEQ_BIT  = 0; // 0 normal, 1 high/low stepfire
  localparam int CTRL_HOLD_BIT = 1; // keeps the sequence in standby
  localparam int CTRL_CLR_BIT  = 2; // write one: leave lockout
  localparam logic [1:0] CTRL_RST = 2'h0;

  // ==========================================================
  // motor positions
  localparam logic [1:0] MOT_LOW  = 2'h0;
  localparam logic [1:0] MOT_HIGH = 2'h1;
  localparam logic [1:0] MOT_MOD  = 2'h2;

  typedef enum logic [3:0] {
    ST_INIT    = 4'h0,
    ST_STANDBY = 4'h1,
    ST_TRANS   = 4'h2,
    ST_N1      = 4'h3,
    ST_N1_END  = 4'h4,
    ST_N2      = 4'h5,
    ST_N2_HOLD = 4'h6,
    ST_N3      = 4'h7,
    ST_HL1     = 4'h8,
    ST_HL2     = 4'h9,
    ST_LOCKOUT = 4'ha
  } bsc_state_t;

  // field inputs from the master controller and the amplifier
  typedef struct packed {
    logic run_request_input;
    logic proceed_to_main_input;
    logic aux_function_three_input;
    logic release_to_run_input;
    logic limits_complete;
    logic low_fire_position;
    logic flame_sensed;
  } bsc_in_t;

  // load outputs
  typedef struct packed {
    logic       igniter;
    logic       pilot;
    logic       main_valve;
    logic       air_valve;
    logic       flame_proven;
    logic       alarm;
    logic [1:0] motor_pos;
  } bsc_out_t;

endpackage

//--- verilog/bsc_sequencer.sv
// burner start-up sequencer with an ahb-lite register slave
// assumes field inputs are already synchronous to hclk and debounced
// electrically; supply fault detectors sit outside and drive levels
`timescale 1ns/1ps

// Function
// - power-up: Initiate, then Standby after ten seconds
// - supply fault holds Initiate, then ten more seconds
// - fault indication stays at least five seconds
// - run request leaves Standby, hold keeps it
// - part one only from Standby, three inputs on
// - part one: igniter, pilot, low fire only
// - part one lockout: low fire after 2s, limits
// - one-second transition precedes part one
// - igniter off after four seconds, no flame lockout
// - flame: hold without proceed, else part two
// - part two: main, air, flame proven, pilot on
// - part two five seconds, flame/low-fire lockout
// - part two end: back, hold, or part three
// - part three outputs; limits or flame lockout
// - part three lockout: release without proceed
// - part three both on: modulate motor
// - proceed only: low fire, alarm after 4 min
// - both off: alarm 4 min, lockout 8 min
// - both off: debounced low fire returns to part one
// - part three persists, standby on run drop
// - stepfire part one: igniter, pilot, low fire
// - stepfire part one four seconds, flame checked
// - lockout on timeout or wrong input
module bsc_sequencer #(
  parameter int CYC_PER_SEC = bsc_pkg::SEC_CYC
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire bsc_pkg::bsc_in_t  field_in,
  input  wire logic [3:0]        supply_fault_in,
  output bsc_pkg::bsc_out_t      load_out,
  output logic [3:0]             fault_ind_out,
  output logic                   lockout_out
);

  // ==========================================================
  // state and timers
  bsc_pkg::bsc_state_t state_ff, nxt_state;
  logic [31:0] pre_ff;
  logic [8:0]  sec_ff;
  logic [2:0]  fhold_ff;
  logic [1:0]  deb_ff;
  logic [1:0]  ctrl_ff;
  logic        clr_ff;
  logic        wr_ff;
  logic [7:0]  waddr_ff;

  wire logic run     = field_in.run_request_input;
  wire logic proceed = field_in.proceed_to_main_input;
  wire logic release_in = field_in.release_to_run_input;
  wire logic limits  = field_in.limits_complete;
  wire logic low_fire = field_in.low_fire_position;
  wire logic flame   = field_in.flame_sensed;
  wire logic any_fault = |supply_fault_in;

  // restart timing on entry; in initiate a fault restarts the wait too
  wire logic restart = (nxt_state != state_ff) ||
                       (state_ff == bsc_pkg::ST_INIT && any_fault);
  wire logic tick = (pre_ff == 32'(CYC_PER_SEC - 1));
  wire logic n3_low_alarm = !release_in && !low_fire &&
                            (sec_ff >= bsc_pkg::ALARM_S);

  // ==========================================================
  // sequence
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      bsc_pkg::ST_INIT: begin
        if (!any_fault && sec_ff >= bsc_pkg::INIT_S)
          nxt_state = bsc_pkg::ST_STANDBY;
      end
      bsc_pkg::ST_STANDBY: begin
        // a hold or any missing interlock keeps the burner off
        if (run && !ctrl_ff[bsc_pkg::CTRL_HOLD_BIT] && limits && low_fire)
          nxt_state = ctrl_ff[bsc_pkg::CTRL_SEQ_BIT] ?
                      bsc_pkg::ST_HL1 : bsc_pkg::ST_TRANS;
      end
      bsc_pkg::ST_TRANS: begin
        if (!limits)
          nxt_state = bsc_pkg::ST_LOCKOUT;
        else if (sec_ff >= bsc_pkg::TRANS_S)
          nxt_state = bsc_pkg::ST_N1;
      end
      bsc_pkg::ST_N1: begin
        if (!limits || (!low_fire && sec_ff >= bsc_pkg::LF_GRACE_S))
          nxt_state = bsc_pkg::ST_LOCKOUT;
        else if (sec_ff >= bsc_pkg::IGN_S)
          nxt_state = !flame ? bsc_pkg::ST_LOCKOUT :
                      proceed ? bsc_pkg::ST_N2 : bsc_pkg::ST_N1_END;
      end
      bsc_pkg::ST_N1_END: begin
        if (!limits || !low_fire || !flame)
          nxt_state = bsc_pkg::ST_LOCKOUT;
        else if (proceed)
          nxt_state = bsc_pkg::ST_N2;
      end
      bsc_pkg::ST_N2: begin
        // proceed is ignored until the five seconds are over
        if (!flame || !low_fire)
          nxt_state = bsc_pkg::ST_LOCKOUT;
        else if (sec_ff >= bsc_pkg::N2_S)
          nxt_state = !proceed ? bsc_pkg::ST_N1_END :
                      release_in ? bsc_pkg::ST_N3 :
                      bsc_pkg::ST_N2_HOLD;
      end
      bsc_pkg::ST_N2_HOLD: begin
        if (!flame || !low_fire)
          nxt_state = bsc_pkg::ST_LOCKOUT;
        else if (!proceed)
          nxt_state = bsc_pkg::ST_N1_END;
        else if (release_in)
          nxt_state = bsc_pkg::ST_N3;
      end
      bsc_pkg::ST_N3: begin
        if (!limits || !flame)
          nxt_state = bsc_pkg::ST_LOCKOUT;
        else if (!proceed && release_in)
          nxt_state = bsc_pkg::ST_LOCKOUT;
        else if (!proceed && sec_ff >= bsc_pkg::LOCK_S)
          nxt_state = bsc_pkg::ST_LOCKOUT;
        else if (!run)
          nxt_state = bsc_pkg::ST_STANDBY;
        else if (!proceed && low_fire && deb_ff >= bsc_pkg::DEB_S)
          nxt_state = bsc_pkg::ST_N1_END;
      end
      bsc_pkg::ST_HL1: begin
        if (!limits)
          nxt_state = bsc_pkg::ST_LOCKOUT;
        else if (sec_ff >= bsc_pkg::HL1_S)
          nxt_state = flame ? bsc_pkg::ST_HL2 :
                      bsc_pkg::ST_LOCKOUT;
      end
      bsc_pkg::ST_HL2: begin
        if (!flame)
          nxt_state = bsc_pkg::ST_LOCKOUT;
        else if (!run)
          nxt_state = bsc_pkg::ST_STANDBY;
      end
      bsc_pkg::ST_LOCKOUT: begin
        // only software leaves lockout, through a fresh initiate
        if (clr_ff)
          nxt_state = bsc_pkg::ST_INIT;
      end
      default: nxt_state = bsc_pkg::ST_LOCKOUT;
    endcase
  end

  // ==========================================================
  // outputs decoded from the state being entered
  bsc_pkg::bsc_out_t nxt_out;
  always_comb begin
    nxt_out = '0;
    nxt_out.motor_pos = bsc_pkg::MOT_LOW;
    unique case (nxt_state)
      bsc_pkg::ST_N1, bsc_pkg::ST_HL1: begin
        nxt_out.igniter = !(nxt_state == bsc_pkg::ST_N1 && !restart &&
                            sec_ff >= bsc_pkg::IGN_S);
        nxt_out.pilot   = 1'b1;
      end
      bsc_pkg::ST_N1_END, bsc_pkg::ST_HL2: begin
        nxt_out.pilot        = 1'b1;
        nxt_out.flame_proven = 1'b1;
      end
      bsc_pkg::ST_N2, bsc_pkg::ST_N2_HOLD, bsc_pkg::ST_N3: begin
        nxt_out.pilot        = 1'b1;
        nxt_out.flame_proven = 1'b1;
        nxt_out.main_valve   = 1'b1;
        nxt_out.air_valve    = 1'b1;
        if (nxt_state == bsc_pkg::ST_N3 && proceed && release_in)
          nxt_out.motor_pos = bsc_pkg::MOT_MOD;
        if (nxt_state == bsc_pkg::ST_N3 && !restart && n3_low_alarm)
          nxt_out.alarm = 1'b1;
      end
      bsc_pkg::ST_LOCKOUT: nxt_out.alarm = 1'b1;
      default: ;
    endcase
  end

  // ==========================================================
  // second prescaler and state timer, both restart on entry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_ff <= 32'h0;
      sec_ff <= 9'h000;
    end else if (restart) begin
      pre_ff <= 32'h0;
      sec_ff <= 9'h000;
    end else if (tick) begin
      pre_ff <= 32'h0;
      sec_ff <= (sec_ff == 9'h1ff) ? sec_ff : sec_ff + 9'h001;
    end else begin
      pre_ff <= pre_ff + 32'h1;
    end
  end

  // fault indication: each condition sticks until five quiet seconds;
  // one extra tick is counted because the prescaler may be mid-second
  // when the fault clears, and a short first second must not count
  logic [2:0] nxt_fhold;
  assign nxt_fhold = any_fault ? 3'h0 :
                     (tick && fhold_ff <= bsc_pkg::FAULT_IND_S) ?
                     fhold_ff + 3'h1 : fhold_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fhold_ff      <= 3'h0;
      fault_ind_out <= 4'h0;
    end else begin
      fhold_ff <= nxt_fhold;
      if (any_fault)
        fault_ind_out <= fault_ind_out | supply_fault_in;
      else if (fhold_ff > bsc_pkg::FAULT_IND_S)
        fault_ind_out <= 4'h0;
    end
  end

  // low-fire debounce in part three, counted in second ticks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      deb_ff <= 2'h0;
    else if (state_ff != bsc_pkg::ST_N3 || !low_fire)
      deb_ff <= 2'h0;
    else if (tick && deb_ff != bsc_pkg::DEB_S)
      deb_ff <= deb_ff + 2'h1;
  end

  // state and registered load outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff    <= bsc_pkg::ST_INIT;
      load_out    <= '0;
      lockout_out <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      load_out    <= nxt_out;
      lockout_out <= (nxt_state == bsc_pkg::ST_LOCKOUT);
    end
  end

  // ==========================================================
  // ahb-lite slave: zero wait states, always okay
  wire logic       take    = hsel && hready && htrans[1];
  wire logic [7:0] a_idx   = haddr[7:0];
  wire logic       a_ok    = (haddr[31:8] == 24'h0);
  wire logic [31:0] status_word = {16'h0, fault_ind_out, lockout_out,
                                   3'h0, 4'(state_ff), 4'h0};
  wire logic [31:0] rd_word =
    !a_ok                        ? 32'h0 :
    (a_idx == bsc_pkg::REG_CTRL)   ? {30'h0, ctrl_ff} :
    (a_idx == bsc_pkg::REG_STATUS) ? (status_word | {24'h0,
                                      load_out}) :
    (a_idx == bsc_pkg::REG_TIMER)  ? {23'h0, sec_ff} : 32'h0;
  wire logic wr_ctrl = wr_ff && (waddr_ff == bsc_pkg::REG_CTRL);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
      wr_ff     <= 1'b0;
      waddr_ff  <= 8'h00;
    end else begin
      wr_ff    <= take && hwrite && a_ok;
      waddr_ff <= a_idx;
      if (take && !hwrite)
        hrdata <= rd_word;
    end
  end

  // control register; the clear bit is a one-cycle pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= bsc_pkg::CTRL_RST;
      clr_ff  <= 1'b0;
    end else begin
      clr_ff <= wr_ctrl && hwdata[bsc_pkg::CTRL_CLR_BIT];
      if (wr_ctrl)
        ctrl_ff <= hwdata[1:0];
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_INIT_HOLD: assert property (
    state_ff == bsc_pkg::ST_INIT && any_fault |=>
    state_ff == bsc_pkg::ST_INIT && sec_ff == 9'h000)
    else $error("initiate left during supply fault");
  AST_FAULT_IND: assert property (
    any_fault |=> (fault_ind_out != 4'h0) [*2])
    else $error("fault indication dropped early");
  AST_N1_FROM_TRANS: assert property (
    state_ff == bsc_pkg::ST_N1 && $past(state_ff) != bsc_pkg::ST_N1 |->
    $past(state_ff) == bsc_pkg::ST_TRANS)
    else $error("part one entered without transition");
  AST_N1_OUT: assert property (
    state_ff == bsc_pkg::ST_N1 && sec_ff < bsc_pkg::IGN_S |->
    load_out.igniter && load_out.pilot && !load_out.main_valve &&
    !load_out.air_valve && !load_out.flame_proven)
    else $error("part one outputs wrong");
  AST_N1_LIMITS: assert property (
    state_ff == bsc_pkg::ST_N1 && !limits |=>
    state_ff == bsc_pkg::ST_LOCKOUT ##1 load_out.alarm)
    else $error("limits loss did not lock out");
  AST_IGN_OFF: assert property (
    state_ff == bsc_pkg::ST_N1 && sec_ff >= bsc_pkg::IGN_S |=>
    !load_out.igniter)
    else $error("igniter on after trial");
  AST_N3_OUT: assert property (
    state_ff == bsc_pkg::ST_N3 |-> !load_out.igniter &&
    load_out.pilot && load_out.main_valve && load_out.air_valve &&
    load_out.flame_proven)
    else $error("part three outputs wrong");
  AST_N3_LOCK: assert property (
    state_ff == bsc_pkg::ST_N3 && !proceed && release_in |=>
    state_ff == bsc_pkg::ST_LOCKOUT)
    else $error("release without proceed not locked out");
  AST_N3_MOD: assert property (
    state_ff == bsc_pkg::ST_N3 && proceed && release_in && run &&
    limits && flame |=> load_out.motor_pos == bsc_pkg::MOT_MOD)
    else $error("motor not modulating");
  AST_N2_TIME: assert property (
    state_ff == bsc_pkg::ST_N2 && sec_ff < bsc_pkg::N2_S |=>
    state_ff inside {bsc_pkg::ST_N2, bsc_pkg::ST_LOCKOUT})
    else $error("part two left early");
  AST_SEQ_ENTRY: assert property (
    state_ff inside {bsc_pkg::ST_TRANS, bsc_pkg::ST_HL1} &&
    $past(state_ff) != state_ff |->
    $past(state_ff) == bsc_pkg::ST_STANDBY && $past(run) &&
    $past(limits) && $past(low_fire))
    else $error("sequence entered without interlocks");
  AST_N2_OUT: assert property (
    state_ff == bsc_pkg::ST_N2 |-> !load_out.igniter && load_out.pilot &&
    load_out.main_valve && load_out.air_valve && load_out.flame_proven &&
    load_out.motor_pos == bsc_pkg::MOT_LOW)
    else $error("part two outputs wrong");
  AST_LOCK_SAFE: assert property (
    lockout_out |-> load_out.alarm && !load_out.igniter &&
    !load_out.pilot && !load_out.main_valve)
    else $error("lockout left a valve open");

  // cycles since the last supply fault, saturating; only the checks
  // read it, so the indication is timed apart from the prescaler
  localparam int FAULT_IND_CYC = int'(bsc_pkg::FAULT_IND_S) * CYC_PER_SEC;
  logic [31:0] quiet_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      quiet_ff <= 32'hffffffff;
    else if (any_fault)
      quiet_ff <= 32'h0;
    else if (quiet_ff != 32'hffffffff)
      quiet_ff <= quiet_ff + 32'h1;
  end

  AST_FAULT_MIN: assert property (
    quiet_ff < 32'(FAULT_IND_CYC) |-> fault_ind_out != 4'h0)
    else $error("fault indication shorter than five seconds");

  COV_N3: cover property (state_ff == bsc_pkg::ST_N3);
  COV_LOCK: cover property (state_ff == bsc_pkg::ST_LOCKOUT);
  COV_HL2: cover property (state_ff == bsc_pkg::ST_HL2);
  COV_STBY: cover property (
    state_ff == bsc_pkg::ST_INIT ##1 state_ff == bsc_pkg::ST_STANDBY);

endmodule

//--- tb/bsc_master_model.sv
// master controller and flame amplifier seen by the sequencer
// assumes the bench sets the wanted levels on cmd at clock edges
`timescale 1ns/1ps

module bsc_master_model (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic [5:0]        cmd,
  input  wire bsc_pkg::bsc_out_t load_out,
  output bsc_pkg::bsc_in_t       field_in
);
  logic [2:0] aux_ff;

  // ==========================================================
  // field levels
  // cmd is run, proceed, release, limits, low fire, flame ok; levels
  // lag one edge like relays, flame shows only while the pilot is open,
  // and the unused input toggles so nothing may lean on it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      field_in <= '0;
      aux_ff   <= 3'h0;
    end else begin
      aux_ff   <= aux_ff + 3'h1;
      field_in <= {cmd[5:4], aux_ff[2], cmd[3:1],
                   cmd[0] & load_out.pilot};
    end
  end
endmodule

//--- tb/test_burner_sequence_controller.sv
// self-checking bench for the burner sequencer
// assumes a fast second of 20 cycles; master model drives the field
`timescale 1ns/1ps

module test_burner_sequence_controller;
  localparam int CPS = 20; // short second keeps minutes affordable
  logic              hclk;
  logic              hresetn;
  logic              hsel;
  logic              hwrite;
  logic              hreadyout;
  logic              hresp;
  logic [31:0]       haddr;
  logic [31:0]       hwdata;
  logic [31:0]       hrdata;
  logic [31:0]       rd;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [5:0]        cmd;
  logic [3:0]        sfault;
  logic [3:0]        fault_ind;
  logic              lockout;
  bsc_pkg::bsc_in_t  field;
  bsc_pkg::bsc_out_t lo;
  int                mismatches;
  int                tests_run;
  int                n;

  // ==========================================================
  // design and partner
  bsc_sequencer #(.CYC_PER_SEC(CPS)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .field_in(field), .supply_fault_in(sfault),
    .load_out(lo), .fault_ind_out(fault_ind), .lockout_out(lockout));
  bsc_master_model master (
    .hclk(hclk), .hresetn(hresetn), .cmd(cmd), .load_out(lo),
    .field_in(field));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // ==========================================================
  // compare tasks and helpers
  task automatic chk_bit(input logic g, input logic e, input string m);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e,
                          input string m);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t %s got %h", $time, m, g);
    end
  endtask
  task automatic chk_span(input int g, input int l, input int h,
                          input string m);
    tests_run++;
    if (g < l || g > h) begin
      mismatches++;
      $display("MISMATCH %0t %s took %0d", $time, m, g);
    end
  endtask
  // settle past the edge so outputs are never sampled in a race
  task automatic cyc(input int k);
    repeat (k) @(posedge hclk);
    #1;
  endtask
  task automatic drive(input logic [5:0] c);
    @(posedge hclk);
    cmd <= c;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return lo.igniter;
      1: return lo.main_valve;
      2: return lockout;
      3: return lo.alarm;
      default: return lo.motor_pos == bsc_pkg::MOT_MOD;
    endcase
  endfunction
  // counts cycles until the chosen output takes value v
  task automatic wait_for(input int s, input logic v, input int lim);
    n = 0;
    #1;
    while (pick(s) !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic do_reset(input logic [5:0] c);
    @(posedge hclk);
    hresetn <= 1'b0;
    cmd     <= c;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  // single word transfer; read data is taken at the data phase edge
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs;
    #1;
    chk_word({24'h0, lo}, 32'h0, "loads after reset");
    ahb(1'b0, bsc_pkg::REG_CTRL, 32'h0);
    chk_word(rd, 32'h0, "ctrl reset value");
    chk_bit(hresp, 1'b0, "okay response");
    ahb(1'b1, 8'h0c, 32'hffffffff);
    ahb(1'b0, 8'h0c, 32'h0);
    chk_word(rd, 32'h0, "unmapped read");
    ahb(1'b1, bsc_pkg::REG_CTRL, 32'h7);
    ahb(1'b0, bsc_pkg::REG_CTRL, 32'h0);
    chk_word(rd, 32'h3, "ctrl readback");
    ahb(1'b1, bsc_pkg::REG_CTRL, 32'h0);
    $display("register test done");
  endtask
  task automatic t_start;
    do_reset(6'h3f);
    wait_for(0, 1'b1, 400);
    chk_span(n, 11 * CPS, 13 * CPS, "ignition start");
    chk_word({24'h0, lo}, 32'hc0, "part one loads");
    wait_for(0, 1'b0, 200);
    chk_span(n, 4 * CPS - 2, 5 * CPS, "ignition trial");
    cyc(2);
    chk_word({24'h0, lo}, 32'h78, "part two loads");
    wait_for(4, 1'b1, 200);
    chk_span(n, 5 * CPS - 4, 6 * CPS, "part two time");
    chk_word({24'h0, lo}, 32'h7a, "part three");
    drive(6'h2f);
    wait_for(2, 1'b1, 10);
    chk_span(n, 1, 4, "release alone");
    $display("start test done");
  endtask
  task automatic t_hold;
    drive(6'h27);
    ahb(1'b1, bsc_pkg::REG_CTRL, 32'h6);
    cyc(15 * CPS);
    chk_bit(lo.igniter, 1'b0, "hold keeps standby");
    ahb(1'b1, bsc_pkg::REG_CTRL, 32'h0);
    wait_for(0, 1'b1, 100);
    chk_span(n, CPS, 3 * CPS, "start after hold");
    wait_for(0, 1'b0, 200);
    cyc(10 * CPS);
    chk_word({24'h0, lo}, 32'h48, "proven hold");
    drive(6'h37);
    wait_for(1, 1'b1, 10);
    chk_span(n, 1, 4, "proceed to part two");
    drive(6'h35);
    wait_for(2, 1'b1, 10);
    chk_span(n, 1, 4, "low fire lost");
    $display("hold test done");
  endtask
  task automatic t_n3;
    drive(6'h37);
    ahb(1'b1, bsc_pkg::REG_CTRL, 32'h4);
    wait_for(1, 1'b1, 600);
    cyc(8 * CPS);
    chk_word({24'h0, lo}, 32'h78, "hold without release");
    drive(6'h3f);
    wait_for(4, 1'b1, 10);
    chk_span(n, 1, 4, "release enters part three");
    drive(6'h37);
    cyc(4);
    chk_word({24'h0, lo}, 32'h78, "low fire commanded");
    drive(6'h27);
    wait_for(1, 1'b0, 100);
    chk_span(n, 2 * CPS - 2, 4 * CPS, "debounced return");
    chk_word({24'h0, lo}, 32'h48, "end of part one");
    drive(6'h3f);
    wait_for(4, 1'b1, 200);
    drive(6'h1f);
    wait_for(1, 1'b0, 10);
    chk_span(n, 1, 4, "run drop");
    chk_bit(lockout, 1'b0, "standby entered");
    $display("part three test done");
  endtask
  task automatic t_long;
    drive(6'h3f);
    wait_for(4, 1'b1, 600);
    drive(6'h25);
    wait_for(3, 1'b1, 6000);
    chk_span(n, 239 * CPS, 241 * CPS, "alarm at four");
    wait_for(2, 1'b1, 6000);
    chk_span(n, 239 * CPS, 241 * CPS, "lockout at eight");
    $display("long hold test done");
  endtask
  task automatic t_step;
    drive(6'h3f);
    ahb(1'b1, bsc_pkg::REG_CTRL, 32'h5);
    wait_for(0, 1'b1, 600);
    chk_word({24'h0, lo}, 32'hc0, "stepfire part one");
    wait_for(0, 1'b0, 200);
    chk_span(n, 4 * CPS - 2, 5 * CPS, "stepfire trial");
    cyc(4);
    chk_bit(lockout, 1'b0, "flame advances");
    chk_bit(lo.flame_proven, 1'b1, "part two proven");
    $display("stepfire test done");
  endtask
  // third reset, this one in mid-run, a short fault, a trial with no flame, then
  // a limits loss inside part one
  task automatic t_fault;
    do_reset(6'h3e);
    cyc(3 * CPS);
    @(posedge hclk);
    sfault <= 4'h2;
    cyc(CPS);
    @(posedge hclk);
    sfault <= 4'h0;
    cyc(4 * CPS);
    chk_word({28'h0, fault_ind}, 32'h2, "fault still shown");
    wait_for(0, 1'b1, 400);
    chk_span(n + 4 * CPS, 11 * CPS, 13 * CPS, "after fault");
    wait_for(2, 1'b1, 200);
    chk_span(n, 4 * CPS - 2, 5 * CPS, "no flame");
    drive(6'h3f);
    ahb(1'b1, bsc_pkg::REG_CTRL, 32'h4);
    wait_for(0, 1'b1, 400);
    drive(6'h3b);
    wait_for(2, 1'b1, 10);
    chk_span(n, 1, 4, "limits lost in part one");
    $display("fault test done");
  endtask

  // ==========================================================
  // main sequence, watchdog and verdict
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans, cmd, sfault} = '0;
    hsize      = 3'h2;
    mismatches = 0;
    tests_run  = 0;
    do_reset(6'h00);
    t_regs;
    t_start;
    t_hold;
    t_n3;
    t_long;
    t_step;
    t_fault;
    wrap_up;
  end
  // the whole run needs about 12400 cycles
  initial begin
    repeat (40000) @(posedge hclk);
    mismatches++;
    $display("MISMATCH %0t watchdog expired", $time);
    wrap_up;
  end
endmodule
